// >>> core/usart_receiver_path.sv
`timescale 1ns/1ps
`default_nettype none

module usart_receiver_path
   import usart_rx_pkg::*;
(
   input  wire logic          sys_clk_in,
   input  wire logic          rst_n_in,
   input  wire logic          xfer_clk_in,
   input  wire rx_config_type cfg_in,
   input  wire logic          rx_done_irq_enable_in,
   input  wire logic          rxd_pin_in,
   input  wire logic          port_out_value_in,
   input  wire logic          port_out_enable_in,
   input  wire logic          data_read_in,
   output logic               rxd_pin_out,
   output logic               rxd_pin_oe_out,
   output logic               port_in_value_out,
   output logic               rx_complete_out,
   output logic               rx_irq_out,
   output rx_entry_type       rx_head_out
);

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   // Data bits plus the optional parity bit
   function automatic logic [3:0] frame_bits(input logic [2:0] sz,
                                             input logic       par_en);
      return data_bits(sz) + {3'h0, par_en};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Synchronous-mode shifter on the external transfer clock

   // Enable and pin both pass two flops in this domain.
   // The finished frame is held in frame and stop until the next
   // frame ends; only the toggle crosses, so the word is stable
   // whenever the system side sees the toggle move.
   typedef struct packed {
      logic       en_s1;
      logic       en_s2;
      logic       rxd_s1;
      logic       rxd_s2;
      logic [9:0] shift;
      logic [3:0] cnt;
      logic       busy;
      logic       toggle;
      logic [9:0] frame;
      logic       stop;
   } xfer_state_type;

   xfer_state_type x_q;
   xfer_state_type x_d;
   logic [3:0]     xlast;

   always_comb begin
      x_d        = x_q;
      x_d.en_s1  = cfg_in.enable & cfg_in.sync_mode;
      x_d.en_s2  = x_q.en_s1;
      x_d.rxd_s1 = rxd_pin_in;
      x_d.rxd_s2 = x_q.rxd_s1;
      xlast      = frame_bits(cfg_in.char_size, cfg_in.parity_en);

      if (!x_q.en_s2) begin
         x_d.busy = 1'b0;
         x_d.cnt  = BIT_CNT_RESET;
      end else if (!x_q.busy) begin
         // Low line on a transfer clock edge opens a frame
         if (!x_q.rxd_s2) begin
            x_d.busy = 1'b1;
            x_d.cnt  = BIT_CNT_RESET;
         end
      end else begin
         x_d.shift = {x_q.rxd_s2, x_q.shift[9:1]};
         if (x_q.cnt == xlast) begin
            // This edge carries the first stop bit
            x_d.busy   = 1'b0;
            x_d.frame  = x_q.shift;
            x_d.stop   = x_q.rxd_s2;
            x_d.toggle = ~x_q.toggle;
         end else begin
            x_d.cnt = x_q.cnt + 4'h1;
         end
      end
   end

   always_ff @(posedge xfer_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         x_q        <= '0;
         x_q.rxd_s1 <= 1'b1;
         x_q.rxd_s2 <= 1'b1;
      end else begin
         x_q <= x_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // System-domain state

   typedef struct packed {
      logic          rxd_s1;
      logic          rxd_s2;
      logic          tog_s1;
      logic          tog_s2;
      logic          tog_s3;
      rx_phase_type  phase;
      logic [15:0]   baud_cnt;
      logic [3:0]    sample;
      logic [2:0]    votes;
      logic [3:0]    bit_idx;
      logic [9:0]    shift;
      logic          waiting;
      rx_entry_type  wait_entry;
      logic          lost;
      rx_entry_type [RX_FIFO_DEPTH-1:0] fifo;
      logic [1:0]    count;
   } rx_state_type;

   rx_state_type s_q;
   rx_state_type s_d;

   logic       tick;
   logic [3:0] last_sample;
   logic [3:0] vote_first;
   logic [3:0] nbits;
   logic       bit_val;

   function automatic rx_entry_type make_entry(input logic [9:0] sh,
                                               input logic [3:0] nb,
                                               input logic       stop,
                                               input logic       par_en,
                                               input logic       odd,
                                               input logic [2:0] sz);
      rx_entry_type e;
      logic [8:0]   d;
      logic         p;
      e = '0;
      d = 9'h000;
      p = 1'b0;
      // Right-align the received bits, zero the unused upper ones
      d = 9'(sh >> (4'ha - nb - {3'h0, par_en}));
      // Drop the parity bit that lands above the data
      d = d & 9'((10'h001 << nb) - 10'h001);
      p = sh[9];
      e.data       = d[7:0];
      e.bit9       = (sz == CHAR_SIZE_NINE) ? d[8] : 1'b0;
      e.frame_err  = ~stop;
      e.parity_err = par_en & ((^d ^ p) != odd);
      return e;
   endfunction

   always_comb begin
      s_d         = s_q;
      s_d.rxd_s1  = rxd_pin_in;
      s_d.rxd_s2  = s_q.rxd_s1;
      s_d.tog_s1  = x_q.toggle;
      s_d.tog_s2  = s_q.tog_s1;
      s_d.tog_s3  = s_q.tog_s2;
      last_sample = cfg_in.double_speed ? OVS_DOUBLE : OVS_NORMAL;
      vote_first  = cfg_in.double_speed ? VOTE_FIRST_DOUBLE
                                        : VOTE_FIRST_NORMAL;
      nbits       = data_bits(cfg_in.char_size);
      tick        = (s_q.baud_cnt == cfg_in.baud_div);
      bit_val     = vote3(s_q.votes);

      // Read pops the head entry
      if (data_read_in && s_q.count != 2'h0) begin
         s_d.fifo[0] = s_q.fifo[1];
         s_d.count   = s_q.count - 2'h1;
      end

      // Waiting frame drains as soon as a slot frees
      if (s_q.waiting && s_d.count != 2'(RX_FIFO_DEPTH)) begin
         s_d.fifo[s_d.count] = s_q.wait_entry;
         s_d.fifo[s_d.count].overrun = s_q.lost;
         s_d.count   = s_d.count + 2'h1;
         s_d.waiting = 1'b0;
         s_d.lost    = 1'b0;
      end

      if (!cfg_in.sync_mode) begin
         s_d.baud_cnt = tick ? 16'h0000 : s_q.baud_cnt + 16'h0001;
         if (tick) begin
            case (s_q.phase)
               RX_IDLE: begin
                  if (!s_q.rxd_s2) begin
                     s_d.phase  = RX_START;
                     s_d.sample = 4'h1;
                  end
               end
               RX_START: begin
                  // Start bit: vote on the centre samples
                  s_d.sample = s_q.sample + 4'h1;
                  if (s_q.sample >= vote_first
                      && s_q.sample <= vote_first + 4'h2) begin
                     s_d.votes = {s_q.votes[1:0], s_q.rxd_s2};
                  end
                  if (s_q.sample == vote_first + 4'h2) begin
                     if (vote3({s_q.votes[1:0], s_q.rxd_s2})) begin
                        s_d.phase = RX_IDLE;
                     end else if (s_q.waiting
                                  && s_q.count == 2'(RX_FIFO_DEPTH)) begin
                        s_d.lost = 1'b1;
                     end
                  end
                  if (s_q.sample == last_sample) begin
                     s_d.sample  = 4'h0;
                     s_d.bit_idx = BIT_CNT_RESET;
                     s_d.phase   = RX_DATA;
                  end
               end
               RX_DATA, RX_STOP: begin
                  s_d.sample = s_q.sample + 4'h1;
                  if (s_q.sample >= vote_first - 4'h1
                      && s_q.sample <= vote_first + 4'h1) begin
                     s_d.votes = {s_q.votes[1:0], s_q.rxd_s2};
                  end
                  if (s_q.sample == vote_first + 4'h2) begin
                     if (s_q.phase == RX_STOP) begin
                        // Only the first stop bit is evaluated
                        s_d.wait_entry = make_entry(s_q.shift, nbits,
                           bit_val, cfg_in.parity_en, cfg_in.parity_odd,
                           cfg_in.char_size);
                        s_d.waiting = 1'b1;
                        s_d.phase   = RX_IDLE;
                     end else begin
                        s_d.shift   = {bit_val, s_q.shift[9:1]};
                        s_d.bit_idx = s_q.bit_idx + 4'h1;
                     end
                  end
                  if (s_q.sample == last_sample) begin
                     s_d.sample = 4'h0;
                     if (s_q.bit_idx == frame_bits(cfg_in.char_size,
                                                   cfg_in.parity_en)) begin
                        s_d.phase = RX_STOP;
                     end
                  end
               end
               default: s_d.phase = RX_IDLE;
            endcase
         end
      end else if (s_q.tog_s3 != s_q.tog_s2) begin
         // Frame finished in the transfer clock domain
         s_d.wait_entry = make_entry(x_q.frame, nbits, x_q.stop,
            cfg_in.parity_en, cfg_in.parity_odd, cfg_in.char_size);
         s_d.waiting = 1'b1;
      end

      if (!cfg_in.enable) begin
         s_d.phase    = RX_IDLE;
         s_d.count    = 2'h0;
         s_d.waiting  = 1'b0;
         s_d.lost     = 1'b0;
         s_d.baud_cnt = BAUD_DIV_RESET;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s_q        <= '0;
         s_q.rxd_s1 <= 1'b1;
         s_q.rxd_s2 <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   // Pin is an input while receiving; otherwise the port owns it
   assign rxd_pin_out       = port_out_value_in;
   assign rxd_pin_oe_out    = ~cfg_in.enable & port_out_enable_in;
   assign port_in_value_out = cfg_in.enable ? 1'b0 : s_q.rxd_s2;
   assign rx_complete_out   = (s_q.count != 2'h0);
   assign rx_irq_out        = rx_complete_out & rx_done_irq_enable_in;
   // Error flags have no write path and feed no interrupt
   assign rx_head_out       = rx_complete_out ? s_q.fifo[0] : '0;

endmodule

`default_nettype wire

// >>> core/usart_rx_pkg.sv
package usart_rx_pkg;

   localparam int          SYS_CLK_HZ        = 40000000;
   localparam int          RX_FIFO_DEPTH     = 2;
   localparam logic [3:0]  OVS_NORMAL        = 4'hf;
   localparam logic [3:0]  OVS_DOUBLE        = 4'h7;
   localparam logic [3:0]  VOTE_FIRST_NORMAL = 4'h7;
   localparam logic [3:0]  VOTE_FIRST_DOUBLE = 4'h3;
   localparam logic [2:0]  CHAR_SIZE_NINE    = 3'h7;
   localparam logic [15:0] BAUD_DIV_RESET    = 16'h0000;
   localparam logic [3:0]  BIT_CNT_RESET     = 4'h0;

   typedef enum logic [1:0] {
      RX_IDLE  = 2'b00,
      RX_START = 2'b01,
      RX_DATA  = 2'b10,
      RX_STOP  = 2'b11
   } rx_phase_type;

   typedef struct packed {
      logic       enable;
      logic       double_speed;
      logic       sync_mode;
      logic [2:0] char_size;
      logic       parity_en;
      logic       parity_odd;
      logic [15:0] baud_div;
   } rx_config_type;

   typedef struct packed {
      logic       bit9;
      logic       frame_err;
      logic       overrun;
      logic       parity_err;
      logic [7:0] data;
   } rx_entry_type;

   function automatic logic [3:0] data_bits(input logic [2:0] size);
      logic [3:0] n;
      n = 4'h5;
      case (size)
         3'h0:    n = 4'h5;
         3'h1:    n = 4'h6;
         3'h2:    n = 4'h7;
         3'h7:    n = 4'h9;
         default: n = 4'h8;
      endcase
      return n;
   endfunction

   function automatic logic vote3(input logic [2:0] s);
      return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
   endfunction

endpackage

// >>> dv/serial_tx_model.sv
`timescale 1ns/1ps
`default_nettype none
module serial_tx_model (
   input  wire logic clk_in,
   output logic      line_out,
   output logic      xclk_out
);
   initial begin
      line_out = 1'b1;
      xclk_out = 1'b0;
   end
   // Start bit, bits LSB first, then one idle bit
   task automatic send(input logic [11:0] bits, input int len, input int spb);
      @(posedge clk_in);
      line_out <= 1'b0;
      repeat (spb) @(posedge clk_in);
      for (int i = 0; i < len; i++) begin
         line_out <= bits[i];
         repeat (spb) @(posedge clk_in);
      end
      line_out <= 1'b1;
      repeat (spb) @(posedge clk_in);
   endtask
   // Clock runs for the frame plus three idle bits before and after it; line moves on its low phase
   task automatic send_sync(input logic [11:0] bits, input int len);
      logic [15:0] f;
      f = {bits, 4'b0111};
      #17;
      for (int i = 0; i < len + 7; i++) begin
         line_out = (i < len + 4) ? f[i] : 1'b1;
         #62.5 xclk_out = 1'b1;
         #62.5 xclk_out = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import usart_rx_pkg::*;
;
   logic          sys_clk, rst_n, irq_en, port_val, port_en, rd;
   logic          rxd, xclk, pin_out, pin_oe, port_in, done, irq;
   rx_config_type cfg;
   rx_entry_type  head;
   int            error_cnt, compares;

   usart_receiver_path u_usart_receiver_path (
      .sys_clk_in(sys_clk), .rst_n_in(rst_n), .xfer_clk_in(xclk),
      .cfg_in(cfg), .rx_done_irq_enable_in(irq_en), .rxd_pin_in(rxd),
      .port_out_value_in(port_val), .port_out_enable_in(port_en),
      .data_read_in(rd), .rxd_pin_out(pin_out), .rxd_pin_oe_out(pin_oe),
      .port_in_value_out(port_in), .rx_complete_out(done),
      .rx_irq_out(irq), .rx_head_out(head));
   serial_tx_model u_serial_tx_model (
      .clk_in(sys_clk), .line_out(rxd), .xclk_out(xclk));

   always #12.5 sys_clk = ~sys_clk;

   task automatic chk(input logic [15:0] seen, input logic [15:0] want);
      compares++;
      if (seen !== want) begin
         error_cnt++;
         $display("BAD %0t seen %h want %h", $time, seen, want);
      end
   endtask

   task automatic report_and_stop;
      if (error_cnt == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   function automatic logic [11:0] entry_of(input logic [8:0] d,
         input int n, input logic [1:0] fl, input logic ovr);
      return {(n == 9) & d[8], fl[0], ovr, cfg.parity_en & fl[1],
              d[7:0] & 8'((1 << n) - 1)};
   endfunction

   // fl[0] breaks the stop bit, fl[1] the parity bit
   task automatic frame(input logic [8:0] d, input int n,
         input logic [1:0] fl);
      logic [11:0] f;
      logic        p;
      p = cfg.parity_odd ^ fl[1];
      f = 12'h000;
      for (int i = 0; i < n; i++) begin
         f[i] = d[i];
         p = p ^ d[i];
      end
      f[n] = cfg.parity_en ? p : ~fl[0];
      f[n + 1] = ~fl[0];
      if (cfg.sync_mode)
         u_serial_tx_model.send_sync(f, n + 1 + 32'(cfg.parity_en));
      else
         u_serial_tx_model.send(f, n + 1 + 32'(cfg.parity_en),
                                cfg.double_speed ? 8 : 16);
   endtask

   task automatic setup(input logic [2:0] sz, input logic pe, odd, ds, sm);
      @(posedge sys_clk);
      cfg.enable <= 1'b0;
      @(posedge sys_clk);
      cfg <= '{1'b0, ds, sm, sz, pe, odd, 16'h0000};
      @(posedge sys_clk);
      cfg.enable <= 1'b1;
      @(posedge sys_clk);
   endtask

   task automatic pop;
      @(posedge sys_clk);
      rd <= 1'b1;
      @(posedge sys_clk);
      rd <= 1'b0;
      @(posedge sys_clk);
      @(negedge sys_clk);
   endtask

   task automatic take(input logic [11:0] e);
      @(negedge sys_clk);
      for (int i = 0; i < 600 && done !== 1'b1; i++) @(negedge sys_clk);
      chk(16'({done, irq}), 16'({1'b1, irq_en}));
      chk(16'(head), 16'(e));
      pop;
   endtask

   task automatic t_formats;
      int n;
      for (int k = 0; k < 5; k++) begin
         n = (k == 4) ? 9 : k + 5;
         setup(k == 4 ? CHAR_SIZE_NINE : 3'(k), k != 0, k[1], k[0], 1'b0);
         irq_en <= k[0];
         frame(9'h15a, n, 2'b00);
         frame(9'h0c3, n, {1'b1, k[0]});
         take(entry_of(9'h15a, n, 2'b00, 1'b0));
         take(entry_of(9'h0c3, n, {1'b1, k[0]}, 1'b0));
      end
   endtask

   task automatic t_overrun;
      setup(3'h3, 1'b0, 1'b0, 1'b0, 1'b0);
      for (int i = 0; i < 4; i++) frame(9'(8'h31 + i), 8, 2'b00);
      take(entry_of(9'h031, 8, 2'b00, 1'b0));
      take(entry_of(9'h032, 8, 2'b00, 1'b0));
      chk(16'(head.overrun), 16'h0001);
      for (int i = 0; i < 4 && done === 1'b1; i++) pop;
      chk(16'(done), 16'h0000);
      frame(9'h077, 8, 2'b00);
      take(entry_of(9'h077, 8, 2'b00, 1'b0));
   endtask

   task automatic t_disable;
      setup(3'h3, 1'b0, 1'b0, 1'b0, 1'b0);
      port_en <= 1'b1;
      port_val <= 1'b1;
      frame(9'h0aa, 8, 2'b00);
      fork
         frame(9'h0ff, 8, 2'b00);
         begin
            repeat (60) @(posedge sys_clk);
            cfg.enable <= 1'b0;
            repeat (3) @(posedge sys_clk);
            @(negedge sys_clk);
            chk({done, irq, pin_oe, port_in, head}, 16'h3000);
            @(posedge sys_clk);
            cfg.enable <= 1'b1;
         end
      join
      repeat (40) @(posedge sys_clk);
      @(negedge sys_clk);
      chk(16'({done, pin_oe}), 16'h0000);
   endtask

   task automatic t_noise;
      for (int d = 0; d < 2; d++) begin
         setup(3'h3, 1'b0, 1'b0, 1'(d), 1'b0);
         u_serial_tx_model.send(12'h000, 0, d ? 3 : 7);
         repeat (200) @(posedge sys_clk);
         @(negedge sys_clk);
         chk(16'(done), 16'h0000);
      end
   endtask

   task automatic t_sync;
      setup(CHAR_SIZE_NINE, 1'b1, 1'b1, 1'b0, 1'b1);
      frame(9'h1e1, 9, 2'b10);
      take(entry_of(9'h1e1, 9, 2'b10, 1'b0));
   endtask

   initial begin
      sys_clk = 1'b0;
      rst_n = 1'b0;
      cfg = '0;
      {irq_en, port_val, port_en, rd} = 4'h0;
      error_cnt = 0;
      compares = 0;
      repeat (4) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_formats;
      t_overrun;
      t_disable;
      t_noise;
      t_sync;
      report_and_stop;
   end

   initial begin
      #1000000;
      error_cnt++;
      report_and_stop;
   end
endmodule
`default_nettype wire

// >>> dv/usart_rx_props.sv
`timescale 1ns/1ps
`default_nettype none
module usart_rx_props
   import usart_rx_pkg::*;
(
   input wire logic          sys_clk_in,
   input wire logic          rst_n_in,
   input wire rx_config_type cfg_in,
   input wire logic          rx_done_irq_enable_in,
   input wire logic          data_read_in,
   input wire logic          port_in_value_out,
   input wire logic          rx_complete_out,
   input wire logic          rx_irq_out,
   input wire rx_entry_type  rx_head_out
);
   default clocking @(posedge sys_clk_in);
   endclocking
   default disable iff (!rst_n_in);
   a_irq_level: assert property (
      rx_irq_out == (rx_complete_out && rx_done_irq_enable_in))
      else $error("irq level");
   a_pin_masked: assert property (
      cfg_in.enable [*3] |-> !port_in_value_out) else $error("pin seen");
   a_off_flush: assert property (
      !cfg_in.enable |=> !rx_complete_out) else $error("no flush");
   a_empty_head: assert property (
      !rx_complete_out |-> rx_head_out == '0) else $error("head not zero");
   a_pop_only: assert property (
      $fell(rx_complete_out) |-> $past(data_read_in) || !$past(cfg_in.enable))
      else $error("flag lost");
   a_narrow_zero: assert property (
      rx_complete_out && cfg_in.char_size == 3'h0
      |-> rx_head_out.data[7:5] == 3'h0) else $error("upper bits");
   a_six_zero: assert property (
      rx_complete_out && cfg_in.char_size == 3'h1
      |-> rx_head_out.data[7:6] == 2'h0) else $error("upper bits six");
   a_parity_off: assert property (
      rx_complete_out && !cfg_in.parity_en |-> !rx_head_out.parity_err)
      else $error("parity flag");
   a_head_holds: assert property (
      rx_complete_out && !data_read_in && cfg_in.enable
      |=> $stable(rx_head_out)) else $error("head moved");
endmodule
bind usart_receiver_path usart_rx_props u_usart_rx_props (
   .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .cfg_in(cfg_in),
   .rx_done_irq_enable_in(rx_done_irq_enable_in),
   .data_read_in(data_read_in), .port_in_value_out(port_in_value_out),
   .rx_complete_out(rx_complete_out), .rx_irq_out(rx_irq_out),
   .rx_head_out(rx_head_out));
`default_nettype wire
